// File: signal_timer_status.sv
// Status and manual-update register block of the signal measurement timer.
//
// How it works
// - Writing one to status bit 7 requests a period holding register load.
// - Hardware clears bit 7 on the same edge that loads the holding register from stage.
// - Bit 1 shows the synchronised window signal level, one means open.
// - Bit 0 reads one while an acquisition runs, zero otherwise.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
module signal_timer_status #(
  parameter int WIDTH = signal_timer_pkg::VALUE_WIDTH
) (
  input wire logic aclk, // Clock, 200 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [3:0] s_axi_awaddr, // Write address.
  input wire logic [2:0] s_axi_awprot, // Write protection, unused.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [3:0] s_axi_araddr, // Read address.
  input wire logic [2:0] s_axi_arprot, // Read protection, unused.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic window_signal, // Window pin, asynchronous.
  input wire logic acquisition_active, // Acquisition running, from core.
  input wire logic timer_running, // Timer running, from core.
  input wire logic [WIDTH-1:0] captured_width, // Live width capture, core.
  output logic [WIDTH-1:0] period_value, // Period holding register.
  output logic [WIDTH-1:0] width_value, // Captured width holding register.
  output logic count_clear // One-cycle pulse clearing the counter.
);

  // ==========================================================================
  // Write channel handshake.
  // Address and data are taken independently; the response waits for both.
  logic aw_have_q;
  logic aw_have_d;
  logic w_have_q;
  logic w_have_d;
  logic [3:0] aw_addr_q;
  logic [3:0] aw_addr_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0] w_strb_q;
  logic [3:0] w_strb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_ready = !aw_have_q && !bvalid_q;
  wire w_ready = !w_have_q && !bvalid_q;
  wire aw_ok = aw_have_q || aw_take;
  wire w_ok = w_have_q || w_take;
  wire wr_fire = aw_ok && w_ok && !bvalid_q;
  wire [3:0] wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_have_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_have_q ? w_strb_q : s_axi_wstrb;

  assign aw_have_d = wr_fire ? 1'b0 : (aw_have_q || aw_take);
  assign w_have_d = wr_fire ? 1'b0 : (w_have_q || w_take);
  assign aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
  assign w_data_d = w_take ? s_axi_wdata : w_data_q;
  assign w_strb_d = w_take ? s_axi_wstrb : w_strb_q;

  // ==========================================================================
  // Write address decode.
  wire wr_status = wr_fire && (wr_addr == signal_timer_pkg::STATUS_OFFSET);
  wire wr_stage = wr_fire &&
                  (wr_addr == signal_timer_pkg::PERIOD_STAGE_OFFSET);
  wire wr_ro = wr_fire &&
               ((wr_addr == signal_timer_pkg::PERIOD_HOLD_OFFSET) ||
                (wr_addr == signal_timer_pkg::WIDTH_HOLD_OFFSET));
  wire wr_known = wr_status || wr_stage || wr_ro;

  assign bvalid_d = wr_fire ? 1'b1 : (bvalid_q && !s_axi_bready);
  assign bresp_d = wr_fire ?
                   (wr_known ? signal_timer_pkg::RESP_OKAY :
                               signal_timer_pkg::RESP_SLVERR) : bresp_q;

  // ==========================================================================
  // Update requests.
  // A software write of one while hardware finishes a request keeps the
  // flag set, so a request made in the completing cycle is never lost.
  signal_timer_pkg::update_req_t req_q;
  signal_timer_pkg::update_req_t req_d;
  signal_timer_pkg::update_req_t req_set;

  wire status_byte = wr_status && wr_strb[0];
  assign req_set.period_update_request = status_byte &&
    wr_data[signal_timer_pkg::PERIOD_REQ_BIT];
  assign req_set.pulse_width_update_request = status_byte &&
    wr_data[signal_timer_pkg::WIDTH_REQ_BIT];
  assign req_set.timer_reset_request = status_byte &&
    wr_data[signal_timer_pkg::RESET_REQ_BIT];

  // Every pending request completes in the cycle after it was seen set,
  // so a clear of the pending flag always follows one transfer.
  assign req_d = req_set;

  // ==========================================================================
  // Period staging, period and width holding registers, and the clear pulse.
  logic [WIDTH-1:0] stage_q;
  logic [WIDTH-1:0] stage_d;
  logic [WIDTH-1:0] period_q;
  logic [WIDTH-1:0] period_d;
  logic [WIDTH-1:0] width_q;
  logic [WIDTH-1:0] width_d;
  logic clear_q;
  logic clear_d;

  always_comb
  begin
    stage_d = stage_q;
    for (int b = 0; b < 3; b++)
    begin
      if (wr_stage && wr_strb[b] && (b * 8 < WIDTH))
      begin
        stage_d[b*8 +: 8] = wr_data[b*8 +: 8];
      end
    end
  end

  // Loading the holding copy only on request keeps the running period
  // stable while software rewrites the stage in several bus writes.
  assign period_d = req_q.period_update_request ? stage_q : period_q;
  assign width_d = req_q.pulse_width_update_request ?
                   captured_width : width_q;
  assign clear_d = req_q.timer_reset_request;

  // ==========================================================================
  // Live status.
  // The window pin passes three flops; a change counts only once the
  // second and third agree, which also rejects a single-cycle glitch.
  logic win_s1_q;
  logic win_s2_q;
  logic win_s3_q;
  logic win_q;
  logic win_d;
  signal_timer_pkg::live_status_t live_q;
  signal_timer_pkg::live_status_t live_d;

  assign win_d = (win_s2_q == win_s3_q) ? win_s3_q : win_q;
  assign live_d.timer_run_status = timer_running;
  assign live_d.window_level_status = win_q;
  assign live_d.acquisition_active_status = acquisition_active;

  // ==========================================================================
  // Read channel.
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;

  logic arready_q;
  wire rd_fire = s_axi_arvalid && arready_q;
  wire rd_status = s_axi_araddr == signal_timer_pkg::STATUS_OFFSET;
  wire rd_stage = s_axi_araddr == signal_timer_pkg::PERIOD_STAGE_OFFSET;
  wire rd_period = s_axi_araddr == signal_timer_pkg::PERIOD_HOLD_OFFSET;
  wire rd_width = s_axi_araddr == signal_timer_pkg::WIDTH_HOLD_OFFSET;

  logic [31:0] status_word;
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[signal_timer_pkg::PERIOD_REQ_BIT] =
      req_q.period_update_request;
    status_word[signal_timer_pkg::WIDTH_REQ_BIT] =
      req_q.pulse_width_update_request;
    status_word[signal_timer_pkg::RESET_REQ_BIT] = req_q.timer_reset_request;
    status_word[signal_timer_pkg::TIMER_RUN_BIT] = live_q.timer_run_status;
    status_word[signal_timer_pkg::WINDOW_BIT] =
      live_q.window_level_status;
    status_word[signal_timer_pkg::ACQ_BIT] =
      live_q.acquisition_active_status;
  end

  wire [31:0] pad_stage = {{(32 - WIDTH){1'b0}}, stage_q};
  wire [31:0] pad_period = {{(32 - WIDTH){1'b0}}, period_q};
  wire [31:0] pad_width = {{(32 - WIDTH){1'b0}}, width_q};

  logic [31:0] rd_word;
  logic rd_known;
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_known = 1'b1;
    if (rd_status)
    begin
      rd_word = status_word;
    end
    else if (rd_stage)
    begin
      rd_word = pad_stage;
    end
    else if (rd_period)
    begin
      rd_word = pad_period;
    end
    else if (rd_width)
    begin
      rd_word = pad_width;
    end
    else
    begin
      rd_known = 1'b0;
    end
  end

  assign rvalid_d = rd_fire ? 1'b1 : (rvalid_q && !s_axi_rready);
  assign rdata_d = rd_fire ? rd_word : rdata_q;
  assign rresp_d = rd_fire ?
                   (rd_known ? signal_timer_pkg::RESP_OKAY :
                               signal_timer_pkg::RESP_SLVERR) : rresp_q;

  // ==========================================================================
  // Ready flops; registered so that every output comes from a flop.
  logic awready_q;
  logic wready_q;

  // ==========================================================================
  // Registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= signal_timer_pkg::RESP_OKAY;
      req_q <= signal_timer_pkg::REQ_RESET;
      stage_q <= signal_timer_pkg::PERIOD_RESET[WIDTH-1:0];
      period_q <= signal_timer_pkg::PERIOD_RESET[WIDTH-1:0];
      width_q <= signal_timer_pkg::WIDTH_RESET[WIDTH-1:0];
      clear_q <= 1'b0;
      live_q <= 3'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= signal_timer_pkg::RESP_OKAY;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      req_q <= req_d;
      stage_q <= stage_d;
      period_q <= period_d;
      width_q <= width_d;
      clear_q <= clear_d;
      live_q <= live_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      win_s1_q <= 1'b0;
      win_s2_q <= 1'b0;
      win_s3_q <= 1'b0;
      win_q <= 1'b0;
    end
    else
    begin
      win_s1_q <= window_signal;
      win_s2_q <= win_s1_q;
      win_s3_q <= win_s2_q;
      win_q <= win_d;
    end
  end

  // Ready is computed from the next state so the registered copy matches.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end
    else
    begin
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q <= !w_have_d && !bvalid_d;
      arready_q <= !rvalid_d;
    end
  end

  // The combinational readies equal the registered ones from the first edge after reset ends.
  wire unused_ok = &{1'b0, aw_ready, w_ready, s_axi_awprot, s_axi_arprot};

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign period_value = period_q;
  assign width_value = width_q;
  assign count_clear = clear_q;

endmodule

// File: signal_timer_pkg.sv
// Package holding register map, field positions and types of the status block.
package signal_timer_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [3:0] STATUS_OFFSET = 4'h0;
  localparam logic [3:0] PERIOD_STAGE_OFFSET = 4'h4;
  localparam logic [3:0] PERIOD_HOLD_OFFSET = 4'h8;
  localparam logic [3:0] WIDTH_HOLD_OFFSET = 4'hc;

  // ==========================================================================
  // Field positions of the status register.
  localparam int PERIOD_REQ_BIT = 7;
  localparam int WIDTH_REQ_BIT = 6;
  localparam int RESET_REQ_BIT = 5;
  localparam int TIMER_RUN_BIT = 2;
  localparam int WINDOW_BIT = 1;
  localparam int ACQ_BIT = 0;

  // ==========================================================================
  // Widths and reset values.
  localparam int VALUE_WIDTH = 24;
  localparam logic [23:0] PERIOD_RESET = 24'hffffff;
  localparam logic [23:0] WIDTH_RESET = 24'h000000;
  localparam logic [2:0] REQ_RESET = 3'h0;

  // ==========================================================================
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Update requests travel together.
  typedef struct packed {
    logic period_update_request;
    logic pulse_width_update_request;
    logic timer_reset_request;
  } update_req_t;

  // Live status sampled from the timer.
  typedef struct packed {
    logic timer_run_status;
    logic window_level_status;
    logic acquisition_active_status;
  } live_status_t;

endpackage

// File: signal_timer_monitor.sv
// Checker of the status block port behaviour.
module signal_timer_monitor #(
  parameter int WIDTH = 24
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire logic [3:0] s_axi_awaddr, // Addr.
  input wire logic s_axi_awvalid, // Valid.
  input wire logic s_axi_awready, // Ready.
  input wire logic [31:0] s_axi_wdata, // Data.
  input wire logic [3:0] s_axi_wstrb, // Strobes.
  input wire logic s_axi_wvalid, // Valid.
  input wire logic s_axi_wready, // Ready.
  input wire logic s_axi_bvalid, // Answer.
  input wire logic [3:0] s_axi_araddr, // Addr.
  input wire logic s_axi_arvalid, // Valid.
  input wire logic s_axi_arready, // Ready.
  input wire logic [31:0] s_axi_rdata, // Data.
  input wire logic s_axi_rvalid, // Answer.
  input wire logic acquisition_active, // Level.
  input wire logic [WIDTH-1:0] period_value, // Hold.
  input wire logic [WIDTH-1:0] width_value, // Hold.
  input wire logic count_clear // Pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Helpers.
  logic wr;
  logic st;
  logic rd0_q;
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign st = wr && s_axi_awaddr == 4'h0 && s_axi_wstrb[0];
  // Only the address of the read in flight matters, so no reset is needed.
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd0_q <= s_axi_araddr == 4'h0;
  // ==========================================================================
  // Properties.
  property p_ans;
    wr |=> s_axi_bvalid;
  endproperty
  a_ans: assert property (p_ans) else $error("write not answered");
  property p_per;
    $changed(period_value) |-> $past(st && s_axi_wdata[7], 2);
  endproperty
  a_per: assert property (p_per) else $error("period load unasked");
  property p_wid;
    $changed(width_value) |-> $past(st && s_axi_wdata[6], 2);
  endproperty
  a_wid: assert property (p_wid) else $error("width load unasked");
  property p_clr;
    count_clear |-> $past(st && s_axi_wdata[5], 2) ##1 !count_clear;
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear pulse");
  property p_acq;
    $rose(s_axi_rvalid) && rd0_q |->
      s_axi_rdata[0] == $past(acquisition_active, 2);
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition bit wrong");
  c_per: cover property (st && s_axi_wdata[7]);
  c_clr: cover property (count_clear);
  c_rd: cover property ($rose(s_axi_rvalid) && rd0_q);
endmodule

// File: signal_timer_status_bench.sv
// Self-checking bench of the status register block.
module signal_timer_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic window_signal = 1'b0, acquisition_active = 1'b0;
  logic timer_running = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [23:0] captured_width = 24'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, count_clear;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [23:0] period_value, width_value;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_clr = 0;

  always #2.5 aclk = ~aclk;
  always @(posedge aclk)
    if (count_clear === 1'b1)
      n_clr <= n_clr + 1;

  signal_timer_status i_dut (.*);

  // ==========================================================================
  // Shared tasks.
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t expected %h got %h", $time, e, g);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 64)
    begin
      n_mismatch++;
      $display("[ERR] %0t bus wait ran out", $time);
      final_report();
    end
  endtask

  // Starting on a fresh edge keeps a strobe from being driven twice at once.
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 64);
    chk({30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    hang(n);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 64);
    chk(e, s_axi_rdata);
    chk({30'h0, (a[1:0] != 2'h0) ? 2'h2 : 2'h0},
        {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
    hang(n);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_period;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h00ffffff);
    wr(4'h4, 32'h00123456, 2'h0);
    chk(32'h00ffffff, {8'h0, period_value});
    wr(4'h0, 32'h00000080, 2'h0);
    @(posedge aclk);
    chk(32'h00123456, {8'h0, period_value});
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h00123456);
  endtask

  task automatic t_width;
    captured_width <= 24'habcdef;
    wr(4'h0, 32'h00000040, 2'h0);
    captured_width <= 24'h000000;
    @(posedge aclk);
    chk(32'h00abcdef, {8'h0, width_value});
    rd(4'hc, 32'h00abcdef);
  endtask

  task automatic t_clear;
    wr(4'h0, 32'h00000020, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'h1, n_clr);
    wr(4'h0, 32'h0, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'h1, n_clr);
  endtask

  // The window pin crosses a synchroniser, so each read waits it out.
  task automatic t_live;
    window_signal <= 1'b1;
    acquisition_active <= 1'b1;
    timer_running <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(4'h0, 32'h7);
    window_signal <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(4'h0, 32'h5);
    acquisition_active <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(4'h0, 32'h4);
  endtask

  task automatic t_bad;
    wr(4'h2, 32'h0, 2'h2);
    rd(4'h6, 32'h0);
    wr(4'h8, 32'h0, 2'h0);
    chk(32'h00123456, {8'h0, period_value});
  endtask

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_period();
    t_width();
    t_clear();
    t_live();
    t_bad();
    final_report();
  end
endmodule

bind signal_timer_status signal_timer_monitor #(.WIDTH(WIDTH)) i_mon (.*);
